// file: ecl_pkg.sv
// constants and state types of the port configuration loader
// assumes: word addresses are byte addresses of the memory map, words are even aligned
package ecl_pkg;

   localparam int PORTS = 4;

   // memory map bases, each group steps two bytes per port
   localparam logic [7:0] MAP_PM_BASE      = 8'h80;
   localparam logic [7:0] MAP_ACK_BASE     = 8'h88;
   localparam logic [7:0] MAP_SLOT_LO_BASE = 8'h90;
   localparam logic [7:0] MAP_SLOT_HI_BASE = 8'h98;
   localparam logic [7:0] MAP_VC_BASE      = 8'ha0;

   // fields inside the power management, ack latency and vc parameter words
   localparam int PM_D3L1_LSB   = 0;
   localparam int PM_L1DLY_LSB  = 2;
   localparam int PM_L0S_LSB    = 4;
   localparam int PM_RXPOL_BIT  = 6;
   localparam int PM_VGA_BIT    = 7;
   localparam int PM_VEND_LSB   = 8;
   localparam int ACK_W         = 15;
   localparam int VC1_SLOT_W    = 7;
   localparam int TC_MAP_LSB    = 8;

   // configuration offsets and positions inside them
   localparam logic [11:0] CFG_LINK_CTL  = 12'h070;
   localparam logic [11:0] CFG_PM_CTL    = 12'h074;
   localparam logic [11:0] CFG_VEND_CTL  = 12'h088;
   localparam logic [11:0] CFG_SLOT_CAP  = 12'h0d4;
   localparam logic [11:0] CFG_VC1_RES   = 12'h15c;
   localparam logic [11:0] CFG_VC1_MAP   = 12'h160;
   localparam int CFG_PM_LSB     = 8;
   localparam int CFG_VGA_BIT    = 31;
   localparam int CFG_ACK_LSB    = 16;
   localparam int CFG_VEND_LSB   = 24;
   localparam int CFG_VC1_LSB    = 16;
   localparam int CFG_TC_LSB     = 0;

   // loader control and status word, reached at this offset of any port
   localparam logic [11:0] CFG_LOADER    = 12'hffc;
   localparam int CTL_RESTART_BIT = 0;
   localparam int STS_READY_BIT   = 0;
   localparam int STS_COUNT_LSB   = 8;

   // reset images of the map words
   localparam logic [15:0] PM_WORD_DEF_P0 = 16'h73a1;
   localparam logic [15:0] PM_WORD_DEF    = 16'h33a1;
   localparam logic [15:0] ACK_WORD_DEF   = 16'h0000;
   localparam logic [15:0] SLOT_LO_DEF    = 16'h0000;
   localparam logic [15:0] SLOT_HI_DEF_P1 = 16'h0008;
   localparam logic [15:0] SLOT_HI_DEF_P2 = 16'h0010;
   localparam logic [15:0] SLOT_HI_DEF_P3 = 16'h0018;
   localparam logic [15:0] VC_WORD_DEF    = 16'h0000;

   typedef enum logic [1:0] {
      ECL_LOADING = 2'b01,
      ECL_READY   = 2'b10
   } ecl_phase_t;

   typedef struct packed {
      ecl_phase_t       phase;
      logic [3:0][6:0]  pm_ctl;
      logic [3:0]       vga_en;
      logic [3:0][7:0]  vend_hi;
      logic [3:0][14:0] ack_lat;
      logic [3:0][31:0] slot_cap;
      logic [3:0][6:0]  vc1_slots;
      logic [3:0][7:0]  tc_map;
      logic [7:0]       word_count;
      logic [31:0]      rdata;
   } ecl_state_t;

endpackage

// file: ecl_loader.sv
// port configuration loader: copies memory image words into per-port config fields
// assumes: the memory reader runs on core_clk and presents one word per valid pulse,
// and pulses load_end with its last word (alone when no valid image exists)
//
// Functional notes
// - fill read-only config fields from memory words
// - port 3 word 86h bits 5:0 to 74h[13:8]
// - pm word: d3-l1, l1 delay, l0s fields
// - pm bit 6 to 74h bit 14
// - pm bit 7 to 70h bit 31
// - pm bits 15:8 to 88h bits 31:24
// - words 88h-8eh bits 14:0 to 70h[30:16]
// - words 92h-96h to d4h low half
// - words 9ah-9eh to d4h high half
// - slot high defaults 0008h, 0010h, 0018h
// - words a0h-a6h bits 6:0 to 15ch[22:16]
// - vc word bits 15:8 to 160h[7:0]
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none

module ecl_loader (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        word_valid,
   input  wire logic [7:0]  word_addr,
   input  wire logic [15:0] word_data,
   input  wire logic        load_end,
   input  wire logic [13:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             load_ready,
   output logic [3:0][6:0]  pm_ctl,
   output logic [3:0]       vga_en,
   output logic [3:0][7:0]  phy_vendor_control_five_hi,
   output logic [3:0][14:0] ack_lat,
   output logic [3:0][31:0] slot_cap,
   output logic [3:0][6:0]  vc1_slots,
   output logic [3:0][7:0]  tc_map
);

   ecl_pkg::ecl_state_t s;
   ecl_pkg::ecl_state_t next_s;

   // reset image built from constants only, so it is safe under async reset
   function automatic ecl_pkg::ecl_state_t reset_image();
      ecl_pkg::ecl_state_t r;
      logic [15:0]         pw;
      r = '0;
      r.phase = ecl_pkg::ECL_LOADING;
      for (int p = 0; p < ecl_pkg::PORTS; p++) begin
         pw = (p == 0) ? ecl_pkg::PM_WORD_DEF_P0 : ecl_pkg::PM_WORD_DEF;
         r.pm_ctl[p]    = pw[ecl_pkg::PM_RXPOL_BIT:ecl_pkg::PM_D3L1_LSB];
         r.vga_en[p]    = pw[ecl_pkg::PM_VGA_BIT];
         r.vend_hi[p]   = pw[15:ecl_pkg::PM_VEND_LSB];
         r.ack_lat[p]   = ecl_pkg::ACK_WORD_DEF[ecl_pkg::ACK_W-1:0];
         r.vc1_slots[p] = ecl_pkg::VC_WORD_DEF[ecl_pkg::VC1_SLOT_W-1:0];
         r.tc_map[p]    = ecl_pkg::VC_WORD_DEF[15:ecl_pkg::TC_MAP_LSB];
      end
      // port 0 has no slot words; others get distinct slot numbers
      r.slot_cap[1] = {ecl_pkg::SLOT_HI_DEF_P1, ecl_pkg::SLOT_LO_DEF};
      r.slot_cap[2] = {ecl_pkg::SLOT_HI_DEF_P2, ecl_pkg::SLOT_LO_DEF};
      r.slot_cap[3] = {ecl_pkg::SLOT_HI_DEF_P3, ecl_pkg::SLOT_LO_DEF};
      return r;
   endfunction

   // true when a map address falls in the group starting at base
   function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
      return (a[7:3] == base[7:3]) && !a[0];
   endfunction

   // one memory word lands in the fields it feeds
   function automatic ecl_pkg::ecl_state_t apply_word(
      input ecl_pkg::ecl_state_t st,
      input logic [7:0]          a,
      input logic [15:0]         d
   );
      ecl_pkg::ecl_state_t r;
      logic [1:0]          p;
      r = st;
      p = a[2:1];
      if (in_group(a, ecl_pkg::MAP_PM_BASE)) begin
         // d3-l1, l1 delay and l0s fields, then rx polarity disable
         r.pm_ctl[p][1:0] = d[ecl_pkg::PM_D3L1_LSB +: 2];
         r.pm_ctl[p][3:2] = d[ecl_pkg::PM_L1DLY_LSB +: 2];
         r.pm_ctl[p][5:4] = d[ecl_pkg::PM_L0S_LSB +: 2];
         r.pm_ctl[p][6]   = d[ecl_pkg::PM_RXPOL_BIT];
         r.vga_en[p]      = d[ecl_pkg::PM_VGA_BIT];
         r.vend_hi[p]     = d[15:ecl_pkg::PM_VEND_LSB];
      end else if (in_group(a, ecl_pkg::MAP_ACK_BASE)) begin
         r.ack_lat[p] = d[ecl_pkg::ACK_W-1:0];
      end else if (in_group(a, ecl_pkg::MAP_SLOT_LO_BASE)) begin
         // word 90h has no port behind it and is dropped
         if (p != 2'd0) begin
            r.slot_cap[p][15:0] = d;
         end
      end else if (in_group(a, ecl_pkg::MAP_SLOT_HI_BASE)) begin
         if (p != 2'd0) begin
            r.slot_cap[p][31:16] = d;
         end
      end else if (in_group(a, ecl_pkg::MAP_VC_BASE)) begin
         r.vc1_slots[p] = d[ecl_pkg::VC1_SLOT_W-1:0];
         r.tc_map[p]    = d[15:ecl_pkg::TC_MAP_LSB];
      end
      return r;
   endfunction

   // read image of one config offset of one port
   function automatic logic [31:0] read_image(
      input ecl_pkg::ecl_state_t st,
      input logic [13:0]         a
   );
      logic [31:0] v;
      logic [1:0]  p;
      v = '0;
      p = a[13:12];
      case (a[11:0])
         ecl_pkg::CFG_LINK_CTL: begin
            v[ecl_pkg::CFG_VGA_BIT] = st.vga_en[p];
            v[ecl_pkg::CFG_ACK_LSB +: ecl_pkg::ACK_W] = st.ack_lat[p];
         end
         ecl_pkg::CFG_PM_CTL: begin
            v[ecl_pkg::CFG_PM_LSB +: 7] = st.pm_ctl[p];
         end
         ecl_pkg::CFG_VEND_CTL: begin
            v[ecl_pkg::CFG_VEND_LSB +: 8] = st.vend_hi[p];
         end
         ecl_pkg::CFG_SLOT_CAP: begin
            v = st.slot_cap[p];
         end
         ecl_pkg::CFG_VC1_RES: begin
            v[ecl_pkg::CFG_VC1_LSB +: ecl_pkg::VC1_SLOT_W] = st.vc1_slots[p];
         end
         ecl_pkg::CFG_VC1_MAP: begin
            v[ecl_pkg::CFG_TC_LSB +: 8] = st.tc_map[p];
         end
         default: begin
            v = '0;
         end
      endcase
      return v;
   endfunction

   always_comb begin
      next_s = s;
      next_s.rdata = '0;

      // restart puts defaults back and reopens the load window
      if (reg_wr && reg_addr[11:0] == ecl_pkg::CFG_LOADER
          && reg_wdata[ecl_pkg::CTL_RESTART_BIT]) begin
         next_s = reset_image();
      end

      case (next_s.phase)
         ecl_pkg::ECL_LOADING: begin
            if (word_valid) begin
               next_s = apply_word(next_s, word_addr, word_data);
               if (next_s.word_count != 8'hff) begin
                  next_s.word_count = next_s.word_count + 8'h01;
               end
            end
            // missing image: no words came, defaults stay
            if (load_end) begin
               next_s.phase = ecl_pkg::ECL_READY;
            end
         end
         ecl_pkg::ECL_READY: begin
            // late words are ignored so fields stay stable once visible
            next_s.phase = ecl_pkg::ECL_READY;
         end
         default: begin
            next_s.phase = ecl_pkg::ECL_LOADING;
         end
      endcase

      if (reg_rd) begin
         if (reg_addr[11:0] == ecl_pkg::CFG_LOADER) begin
            next_s.rdata[ecl_pkg::STS_READY_BIT] = (s.phase == ecl_pkg::ECL_READY);
            next_s.rdata[ecl_pkg::STS_COUNT_LSB +: 8] = s.word_count;
         end else if (s.phase == ecl_pkg::ECL_READY) begin
            next_s.rdata = read_image(s, reg_addr);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= reset_image();
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata                  = s.rdata;
   assign load_ready                 = (s.phase == ecl_pkg::ECL_READY);
   assign pm_ctl                     = s.pm_ctl;
   assign vga_en                     = s.vga_en;
   assign phy_vendor_control_five_hi = s.vend_hi;
   assign ack_lat                    = s.ack_lat;
   assign slot_cap                   = s.slot_cap;
   assign vc1_slots                  = s.vc1_slots;
   assign tc_map                     = s.tc_map;

endmodule

`default_nettype wire

// file: ecl_loader_sva.sv
// checker of the port configuration loader
// assumes: bound to ecl_loader, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ecl_loader_sva (
   input wire logic             core_clk,
   input wire logic             rst,
   input wire logic             word_valid,
   input wire logic [7:0]       word_addr,
   input wire logic [15:0]      word_data,
   input wire logic             load_end,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [13:0]      reg_addr,
   input wire logic [31:0]      reg_rdata,
   input wire logic             load_ready,
   input wire logic [3:0][6:0]  pm_ctl,
   input wire logic [3:0]       vga_en,
   input wire logic [3:0][7:0]  phy_vendor_control_five_hi,
   input wire logic [3:0][14:0] ack_lat,
   input wire logic [3:0][31:0] slot_cap,
   input wire logic [3:0][6:0]  vc1_slots,
   input wire logic [3:0][7:0]  tc_map
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // a word counts only while loading
   wire logic ld = word_valid && !load_ready;
   a_pm_copy: assert property (ld && word_addr == 8'h86 |=>
      pm_ctl[3] == $past(word_data[6:0])) else $error("pm copy");
   a_vga_copy: assert property (ld && word_addr == 8'h80 |=>
      vga_en[0] == $past(word_data[7])) else $error("vga copy");
   a_vend_copy: assert property (ld && word_addr == 8'h84 |=>
      phy_vendor_control_five_hi[2] == $past(word_data[15:8])) else $error("vendor copy");
   a_ack_copy: assert property (ld && word_addr == 8'h8e |=>
      ack_lat[3] == $past(word_data[14:0])) else $error("ack copy");
   a_slot_low: assert property (ld && word_addr == 8'h92 |=>
      slot_cap[1][15:0] == $past(word_data)) else $error("slot low");
   a_slot_high: assert property (ld && word_addr == 8'h9e |=>
      slot_cap[3][31:16] == $past(word_data)) else $error("slot high");
   a_vc_copy: assert property (ld && word_addr == 8'ha0 |=>
      {tc_map[0], vc1_slots[0]} == $past({word_data[15:8], word_data[6:0]}))
      else $error("vc copy");
   a_ready_set: assert property (load_end && !load_ready && !reg_wr |=> load_ready)
      else $error("ready late");
   a_early_read: assert property (reg_rd && !load_ready && reg_addr[11:0] != 12'hffc |=>
      reg_rdata == 32'h0) else $error("early read");
   c_word: cover property (ld ##1 ld);
   c_ready: cover property ($rose(load_ready));
   c_restart: cover property (load_ready && reg_wr ##1 !load_ready);
endmodule
bind ecl_loader ecl_loader_sva u_sva (.*);
`default_nettype wire

// file: ecl_mem.sv
// memory model: walks its word image over the word link on request
// assumes: the bench fills mem before pulsing go
`timescale 1ns/100ps
`default_nettype none
module ecl_mem (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic go,
   input  wire logic empty,
   input  wire logic slow,
   output logic      word_valid,
   output logic [7:0]  word_addr,
   output logic [15:0] word_data,
   output logic      load_end
);
   logic [15:0] mem [0:19];
   int          idx;
   logic        gap;
   always @(posedge core_clk or posedge rst) begin
      word_valid <= 1'b0;
      load_end   <= 1'b0;
      gap        <= !rst && !gap;
      if (rst) begin
         idx       <= 20;
         word_addr <= 8'h00;
         word_data <= 16'h0000;
      end else if (go) begin
         idx <= empty ? 21 : 0;
      end else if (idx == 21) begin
         load_end <= 1'b1;
         idx      <= 20;
      end else if (idx < 20 && !(slow && gap)) begin
         word_valid <= 1'b1;
         word_addr  <= 8'h80 + 8'(2 * idx);
         word_data  <= mem[idx];
         load_end   <= idx == 19;
         idx        <= idx + 1;
      end else begin
         // released link never keeps the last word
         word_addr <= ~word_addr;
         word_data <= ~word_data;
      end
   end
endmodule
`default_nettype wire

// file: test_eeprom_port_config_loader.sv
// self-checking bench of the port configuration loader
// assumes: ecl_loader fed by the memory model
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_port_config_loader;
   logic        core_clk = 1'b0, rst = 1'b1, go = 1'b0, empty = 1'b0, slow = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [13:0] reg_addr = 14'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'h3aec;
   logic        word_valid, load_end, load_ready;
   logic [7:0]  word_addr;
   logic [15:0] word_data, img [0:19];
   logic [11:0] offs [0:5] = '{12'h070, 12'h074, 12'h088, 12'h0d4, 12'h15c, 12'h160};
   logic [63:0] q [$];
   int          err_total = 0, num_checks = 0;
   always #4 core_clk = ~core_clk;
   ecl_loader DUT (.core_clk(core_clk), .rst(rst), .word_valid(word_valid),
      .word_addr(word_addr), .word_data(word_data), .load_end(load_end), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .load_ready(load_ready), .pm_ctl(), .vga_en(), .phy_vendor_control_five_hi(),
      .ack_lat(), .slot_cap(), .vc1_slots(), .tc_map());
   ecl_mem mdl (.core_clk(core_clk), .rst(rst), .go(go), .empty(empty), .slow(slow),
      .word_valid(word_valid), .word_addr(word_addr), .word_data(word_data),
      .load_end(load_end));
   function logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // upper half expected value, lower half mask of the bits this block owns
   function logic [63:0] ex(input int p, input int k);
      case (k)
         0: return {img[p][7], img[4+p][14:0], 16'h0, 32'hffff0000};
         1: return {17'h0, img[p][6:0], 8'h0, 32'h00007f00};
         2: return {img[p][15:8], 24'h0, 32'hff000000};
         3: return {(p == 0) ? 32'h0 : {img[12+p], img[8+p]}, 32'hffffffff};
         4: return {9'h0, img[16+p][6:0], 16'h0, 32'h007f0000};
         default: return {24'h0, img[16+p][15:8], 32'h000000ff};
      endcase
   endfunction
   task chk(input logic [31:0] got, input logic [63:0] em);
      num_checks++;
      if ((got & em[31:0]) !== (em[63:32] & em[31:0])) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, em[63:32]);
      end
   endtask
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      if (rd_d)
         chk(reg_rdata, q.pop_front());
   end
   task automatic rd(input logic [13:0] a, input logic [63:0] em);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      q.push_back(em);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic walk(input logic e);
      @(posedge core_clk);
      empty <= e;
      go    <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      for (int n = 0; n < 100 && load_end !== 1'b1; n++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
   endtask
   task automatic rd_all();
      for (int p = 0; p < 4; p++)
         for (int k = 0; k < 6; k++)
            rd({p[1:0], offs[k]}, ex(p, k));
   endtask
   task give_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      err_total++;
      give_verdict();
   end
   initial begin
      for (int i = 0; i < 20; i++) begin
         lfsr = nx(lfsr);
         img[i] = lfsr[15:0];
         mdl.mem[i] = img[i];
      end
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      rd({2'd1, 12'h0d4}, {32'h0, 32'hffffffff});
      rd({2'd0, 12'hffc}, {32'h0, 32'h1});
      slow <= 1'b1;
      walk(1'b0);
      rd_all();
      $display("test load done");
      // later walk must not touch a loaded image
      for (int i = 0; i < 20; i++)
         mdl.mem[i] = ~img[i];
      slow <= 1'b0;
      walk(1'b0);
      rd_all();
      rd({2'd2, 12'h100}, {32'h0, 32'hffffffff});
      $display("test refuse done");
      @(posedge core_clk);
      reg_addr  <= {2'd3, 12'hffc};
      reg_wdata <= 32'h1;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      rd({2'd0, 12'hffc}, {32'h0, 32'h1});
      for (int i = 0; i < 20; i++)
         img[i] = (i == 0) ? 16'h73a1 : (i < 4) ? 16'h33a1 : 16'h0;
      img[13] = 16'h0008;
      img[14] = 16'h0010;
      img[15] = 16'h0018;
      walk(1'b1);
      rd_all();
      $display("test defaults done");
      repeat (4) @(posedge core_clk);
      give_verdict();
   end
endmodule
`default_nettype wire
